// >>> idt_decode.sv
`timescale 1ns/1ps
`default_nettype none
module idt_decode
	import idt_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic                 clk_en,
	input  wire logic [IDT_OPT_W-1:0] option_word,
	input  wire logic [IDT_IW-1:0]    instr,
	input  wire logic                 instr_valid,
	input  wire logic                 skip_cond,
	output logic                      cycle_strobe,
	output logic                      timer_tick,
	output idt_dec_t                  dec_q,
	output logic                      dec_valid,
	output logic                      busy,
	output logic                      squash
);
	// ----------------------------------------
	// reset synchroniser
	// ----------------------------------------
	logic rst_s1_q, rst_s2_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire logic rstn = rst_s2_q;

	// ----------------------------------------
	// cycle length option
	// ----------------------------------------
	// option word is static but comes from outside, so resynchronise it
	logic opt_s1_q, opt_s2_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			opt_s1_q <= 1'b0;
			opt_s2_q <= 1'b0;
		end else if (clk_en) begin
			opt_s1_q <= option_word[IDT_OPT_CYCLE_LENGTH_SELECT];
			opt_s2_q <= opt_s1_q;
		end
	end
	wire logic cycle_length_select = opt_s2_q;

	// ----------------------------------------
	// oscillator divider
	// ----------------------------------------
	logic [1:0] div_q;
	wire logic [1:0] div_last = cycle_length_select ? 2'(IDT_OSC_LONG - 1)
	                                                : 2'(IDT_OSC_SHORT - 1);
	wire logic cyc_end = (div_q >= div_last);
	// two or four clocks per cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			div_q <= 2'h0;
		else if (clk_en)
			div_q <= cyc_end ? 2'h0 : div_q + 2'h1;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			cycle_strobe <= 1'b0;
		else if (clk_en)
			cycle_strobe <= cyc_end;
	end
	// timer tick once per instruction cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			timer_tick <= 1'b0;
		else if (clk_en)
			timer_tick <= cyc_end;
	end

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	idt_dec_t d;
	always_comb begin
		d = '0;
		d.cls = IDT_C_OTHER;
		// operand fields sit at fixed positions
		// i/o registers share the same address space
		d.reg_addr = instr[5:0];
		d.bit_pos  = instr[8:6];
		// 8 or 10 bit immediates, the long one for jump and call
		d.literal  = (instr[12:11] == 2'h2) ? instr[9:0] : {2'h0, instr[7:0]};
		if (instr[12:10] == 3'b100) begin
			d.cls = IDT_C_LIT10;
			d.two_cycle = 1'b1;
		end else if (instr[12:10] == 3'b101) begin
			d.cls = IDT_C_LIT10;
			d.two_cycle = 1'b1;
		end else if (instr[12:11] == 2'b11) begin
			d.cls = (instr[10:8] == 3'b001) ? IDT_C_RETLIT : IDT_C_LIT8;
			// literal return takes two cycles and pops like any return
			d.two_cycle = (instr[10:8] == 3'b001);
			d.stack_pop = (instr[10:8] == 3'b001);
		end else if (instr[12:10] == 3'b010) begin
			d.cls = instr[9] ? IDT_C_BITSET : IDT_C_BITCLR;
			d.writes_reg = 1'b1;
			d.pc_target = (instr[5:0] == IDT_PC_REG);
		end else if (instr[12:10] == 3'b011) begin
			d.cls = IDT_C_SKIPB;
		end else if (instr == IDT_OP_NOP) begin
			d.cls = IDT_C_NOP;
		end else if (instr[12:6] == 7'h00) begin
			d.cls = IDT_C_CTRL;
			case (instr)
				IDT_OP_SLEEP: begin
					d.wd_clear = 1'b1;
					d.osc_stop = 1'b1;
				end
				IDT_OP_WDCLR: d.wd_clear = 1'b1;
				IDT_OP_ENI: d.int_enable = 1'b1;
				IDT_OP_DISI: d.int_disable = 1'b1;
				IDT_OP_SUBEXIT: begin
					d.stack_pop = 1'b1;
					d.two_cycle = 1'b1;
				end
				IDT_OP_INTEXIT: begin
					d.stack_pop = 1'b1;
					d.int_enable = 1'b1;
					d.two_cycle = 1'b1;
				end
				default: d.cls = IDT_C_CTRL;
			endcase
		end else begin
			d.cls = IDT_C_REG;
			// skip-on-zero groups: dec 0x05 (bits 7:6 = 3 / 1), inc 0x07 (3 / 1)
			if ((instr[12:8] == 5'h05 || instr[12:8] == 5'h07) && instr[6])
				d.cls = IDT_C_SKIPZ;
			// destination is the register when bit 6 set, or clr/mov forms
			d.writes_reg = instr[6] || (instr[12:8] == 5'h00);
			d.pc_target = d.writes_reg && (instr[5:0] == IDT_PC_REG);
		end
		// program counter writes take two cycles
		if (d.pc_target)
			d.two_cycle = 1'b1;
	end

	// ----------------------------------------
	// issue sequencing
	// ----------------------------------------
	typedef enum logic [1:0] {IDT_S_RUN, IDT_S_EXTRA} idt_state_t;
	idt_state_t st_q;
	wire logic is_skip = (dec_q.cls == IDT_C_SKIPB) || (dec_q.cls == IDT_C_SKIPZ);
	// extra cycle for branches and taken skips
	wire logic need_extra = dec_valid && (dec_q.two_cycle || (is_skip && skip_cond));
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			st_q <= IDT_S_RUN;
		else if (clk_en && cyc_end) begin
			case (st_q)
				IDT_S_RUN:   st_q <= need_extra ? IDT_S_EXTRA : IDT_S_RUN;
				IDT_S_EXTRA: st_q <= IDT_S_RUN;
				default:     st_q <= IDT_S_RUN;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dec_q     <= '0;
			dec_valid <= 1'b0;
		end else if (clk_en && cyc_end) begin
			// need_extra is low in the extra cycle, so its end takes the next word
			if (!need_extra) begin
				dec_q     <= d;
				dec_valid <= instr_valid;
			end else begin
				dec_valid <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy   <= 1'b0;
			squash <= 1'b0;
		end else if (clk_en && cyc_end) begin
			busy   <= (st_q == IDT_S_RUN) && need_extra;
			squash <= (st_q == IDT_S_RUN) && need_extra && is_skip && skip_cond;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_short_cycle: assert property (@(posedge clk) disable iff (!rstn)
		(clk_en && cyc_end && !cycle_length_select) |=> (!clk_en || !cyc_end))
		else $error("short cycle length wrong");
	a_div_bound: assert property (@(posedge clk) disable iff (!rstn)
		(!cycle_length_select) |-> (div_q <= 2'h1 || $past(cycle_length_select)))
		else $error("divider overran short cycle");
	a_tick_rate: assert property (@(posedge clk) disable iff (!rstn)
		(clk_en && timer_tick && cycle_length_select && $stable(cycle_length_select))
		|=> !timer_tick)
		else $error("timer tick too fast");
	a_extra_cycle: assert property (@(posedge clk) disable iff (!rstn)
		(clk_en && cyc_end && st_q == IDT_S_RUN && need_extra)
		|=> (st_q == IDT_S_EXTRA && busy && !dec_valid))
		else $error("two-cycle instruction not stretched");
	a_extra_ends: assert property (@(posedge clk) disable iff (!rstn)
		(clk_en && cyc_end && st_q == IDT_S_EXTRA)
		|=> (st_q == IDT_S_RUN && !busy && dec_valid == $past(instr_valid)))
		else $error("extra cycle not ended after one bubble");
	a_sleep_dec: assert property (@(posedge clk) disable iff (!rstn)
		(instr == IDT_OP_SLEEP) |-> (d.wd_clear && d.osc_stop))
		else $error("sleep decode wrong");
	a_wdclr_dec: assert property (@(posedge clk) disable iff (!rstn)
		(instr == IDT_OP_WDCLR) |-> (d.wd_clear && !d.osc_stop))
		else $error("watchdog clear decode wrong");
	a_intexit_dec: assert property (@(posedge clk) disable iff (!rstn)
		(instr == IDT_OP_INTEXIT) |-> (d.stack_pop && d.int_enable && d.two_cycle))
		else $error("interrupt exit decode wrong");
	a_squash_skip: assert property (@(posedge clk) disable iff (!rstn)
		(clk_en && cyc_end && st_q == IDT_S_RUN && dec_valid && is_skip && skip_cond)
		|=> squash)
		else $error("taken skip not squashed");
	c_long_mode: cover property (@(posedge clk) disable iff (!rstn)
		cycle_length_select && cyc_end);
	c_taken_skip: cover property (@(posedge clk) disable iff (!rstn) squash);
	c_pc_write: cover property (@(posedge clk) disable iff (!rstn)
		dec_valid && dec_q.pc_target);
endmodule
`default_nettype wire

// >>> idt_pkg.sv
package idt_pkg;
	localparam int unsigned IDT_IW          = 13;
	localparam int unsigned IDT_OPT_W       = 13;
	// option word field
	localparam int unsigned IDT_OPT_CYCLE_LENGTH_SELECT    = 10;
	// clock figures
	localparam int unsigned IDT_CLK_MHZ     = 40;
	localparam int unsigned IDT_OSC_SHORT   = 2;
	localparam int unsigned IDT_OSC_LONG    = 4;
	// register operand addresses
	localparam logic [5:0]  IDT_PC_REG      = 6'h02;
	// fixed opcodes
	localparam logic [12:0] IDT_OP_NOP      = 13'h0000;
	localparam logic [12:0] IDT_OP_SLEEP    = 13'h0003;
	localparam logic [12:0] IDT_OP_WDCLR    = 13'h0004;
	localparam logic [12:0] IDT_OP_ENI      = 13'h0010;
	localparam logic [12:0] IDT_OP_DISI     = 13'h0011;
	localparam logic [12:0] IDT_OP_SUBEXIT  = 13'h0012;
	localparam logic [12:0] IDT_OP_INTEXIT  = 13'h0013;
	// instruction classes
	typedef enum logic [3:0] {
		IDT_C_NOP, IDT_C_CTRL, IDT_C_REG, IDT_C_BITSET, IDT_C_BITCLR,
		IDT_C_SKIPB, IDT_C_SKIPZ, IDT_C_LIT8, IDT_C_LIT10, IDT_C_RETLIT,
		IDT_C_OTHER
	} idt_class_t;
	typedef struct packed {
		idt_class_t  cls;
		logic [5:0]  reg_addr;
		logic [2:0]  bit_pos;
		logic [9:0]  literal;
		logic        writes_reg;
		logic        pc_target;
		logic        wd_clear;
		logic        osc_stop;
		logic        int_enable;
		logic        int_disable;
		logic        stack_pop;
		logic        two_cycle;
	} idt_dec_t;
endpackage

// >>> idt_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// program memory and skip test source
// ----------------------------------------
module idt_prog_mem
	import idt_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         take,
	output logic [IDT_IW-1:0] instr,
	output logic              instr_valid,
	output logic              skip_cond
);
	logic [IDT_IW-1:0] rom_q [0:255];
	logic              cond_q [0:255];
	logic [7:0]        pc_q;
	// step on an issued word or a squashed follower; a word refused behind
	// a jump is offered again, since this model has no branch target
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			pc_q <= 8'h00;
		else if (take)
			pc_q <= pc_q + 8'h01;
	end
	assign instr       = rom_q[pc_q];
	assign instr_valid = 1'b1;
	assign skip_cond   = cond_q[pc_q - 8'h01];
endmodule
`default_nettype wire

// >>> test_mcu_instruction_decode_timing.sv
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instruction_decode_timing;
	import idt_pkg::*;
	logic                 clk = 1'b0;
	logic                 resetn = 1'b0;
	logic [IDT_OPT_W-1:0] option_word = 13'h0000;
	logic [IDT_IW-1:0]    instr, ins, w;
	logic                 instr_valid, skip_cond, cycle_strobe, timer_tick;
	logic                 dec_valid, busy, squash, pend, pskip, seen, longc;
	idt_dec_t             dec_q;
	int                   error_cnt = 0;
	int                   checked = 0;
	int                   ncyc, ntick;
	logic [31:0]          lf = 32'h7C0F90AB;
	logic [12:0]          hand [0:17] = '{13'h0003, 13'h0004, 13'h0010, 13'h0011, 13'h0012,
		13'h0013, 13'h1123, 13'h1523, 13'h1905, 13'h1855, 13'h0042, 13'h00C2, 13'h0982,
		13'h05C5, 13'h05C5, 13'h0D45, 13'h0A7F, 13'h0000};
	always #12.5 clk = ~clk;
	idt_decode i_dut (.clk(clk), .resetn(resetn), .clk_en(1'b1), .option_word(option_word),
		.instr(instr), .instr_valid(instr_valid), .skip_cond(skip_cond),
		.cycle_strobe(cycle_strobe), .timer_tick(timer_tick), .dec_q(dec_q),
		.dec_valid(dec_valid), .busy(busy), .squash(squash));
	idt_prog_mem i_mem (.clk(clk), .resetn(resetn), .take((dec_valid | squash) & cycle_strobe),
		.instr(instr), .instr_valid(instr_valid), .skip_cond(skip_cond));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic two(input logic [12:0] i);
		two = i[12:11] == 2'b10 || i == 13'h0012 || i == 13'h0013 || i[12:8] == 5'h19
			|| i == 13'h0042 || i == 13'h00C2 || i == 13'h0982;
	endfunction
	function automatic logic skp(input logic [12:0] i);
		skp = i[12:10] == 3'b011 || ((i[12:8] == 5'h05 || i[12:8] == 5'h07) && i[6]);
	endfunction
	task automatic chk_b(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_v(input string nm, input logic [9:0] e, input logic [9:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// monitor: outputs are registered, so sampling on the edge is safe
	// ----------------------------------------
	always @(posedge clk) begin
		ncyc++;
		ntick++;
		if (!resetn) begin
			seen = 1'b0;
			pend = 1'b0;
		end else begin
			if (timer_tick && seen)
				chk_v("tick gap", longc ? 10'h004 : 10'h002, 10'(ntick));
			if (timer_tick)
				ntick = 0;
			if (cycle_strobe && seen) begin
				chk_v("cycle len", longc ? 10'h004 : 10'h002, 10'(ncyc));
				chk_b("valid", !pend, dec_valid);
				chk_b("squash", pend && pskip, squash);
				chk_b("busy", pend, busy);
				pend = 1'b0;
			end
			if (cycle_strobe)
				ncyc = 0;
			if (cycle_strobe && dec_valid) begin
				ins = i_mem.rom_q[i_mem.pc_q];
				seen = 1'b1;
				pskip = skp(ins) && i_mem.cond_q[i_mem.pc_q];
				pend = two(ins) || pskip;
				chk_b("wd clear", ins == 13'h0003 || ins == 13'h0004, dec_q.wd_clear);
				chk_b("osc stop", ins == 13'h0003, dec_q.osc_stop);
				chk_b("pop", ins == 13'h0012 || ins == 13'h0013 || ins[12:8] == 5'h19,
					dec_q.stack_pop);
				chk_b("int en", ins == 13'h0010 || ins == 13'h0013, dec_q.int_enable);
				if (!skp(ins))
					chk_b("two cyc", two(ins), dec_q.two_cycle);
				chk_b("pc wr", two(ins) && !ins[12] && ins[12:6] != 7'h00, dec_q.pc_target);
				if (ins[12:11] == 2'b10)
					chk_v("lit10", ins[9:0], dec_q.literal);
				if (ins[12:11] == 2'b11)
					chk_v("lit8", 10'(ins[7:0]), 10'(dec_q.literal[7:0]));
				if (!ins[12] && ins[12:6] != 7'h00)
					chk_v("reg", 10'(ins[5:0]), 10'(dec_q.reg_addr));
				if (ins[12:11] == 2'b01)
					chk_v("bit", 10'(ins[8:6]), 10'(dec_q.bit_pos));
			end
		end
	end
	initial begin
		for (int i = 0; i < 256; i++) begin
			lf = nxt(lf);
			w = lf[12:0];
			// keep random words off the program counter and off unclear groups
			if (w[12:6] == 7'h00)
				w[6] = 1'b1;
			if (!w[12] && w[5:0] == 6'h02)
				w[0] = 1'b1;
			if (w[12:8] == 5'h05 || w[12:8] == 5'h07)
				w[6] = 1'b0;
			if (w[12:11] == 2'b11)
				w[10:8] = 3'b000;
			i_mem.rom_q[i] = (i < 18) ? hand[i] : w;
			i_mem.cond_q[i] = (i == 13) ? 1'b0 : (i == 14) ? 1'b1 : lf[20];
		end
		for (int ph = 0; ph < 2; ph++) begin
			#2;
			lf = nxt(lf);
			resetn = 1'b0;
			longc = ph[0];
			option_word = lf[12:0];
			option_word[IDT_OPT_CYCLE_LENGTH_SELECT] = ph[0];
			repeat (20) @(posedge clk);
			#2 resetn = 1'b1;
			repeat (700) @(posedge clk);
			$display("phase %0d done, checks %0d", ph, checked);
		end
		stop_test();
	end
	initial begin
		#100000;
		error_cnt++;
		stop_test();
	end
endmodule
`default_nettype wire
